// ===== logic/afp_defines.svh
`ifndef AFP_DEFINES_SVH
`define AFP_DEFINES_SVH
`define AFP_CLK_MHZ 100
`define AFP_DC_PERSIST_MS 420
`define AFP_DC_PERSIST_CYC (`AFP_DC_PERSIST_MS * 1000 * `AFP_CLK_MHZ)
`define AFP_DUTY_LIMIT_PCT 60
`define AFP_TIMEOUT_CYC 1000
`define AFP_ADDR_STATUS 12'h000
`define AFP_ADDR_MASK 12'h004
`define AFP_ADDR_CTRL 12'h008
`define AFP_ADDR_LIVE 12'h00c
`define AFP_ADDR_CONFIG 12'h010
`define AFP_ST_OV 0
`define AFP_ST_UV 1
`define AFP_ST_CLK 2
`define AFP_ST_OC 3
`define AFP_ST_DC 4
`define AFP_ST_OT 5
`define AFP_NUM_ERR 6
`define AFP_CTRL_SD_BIT 0
`define AFP_CTRL_RESET 32'h0000_0001
`define AFP_MASK_RESET 32'h0000_0000
`define AFP_RESP_OKAY 2'b00
`define AFP_RESP_SLVERR 2'b10
`endif

// ===== logic/afp_pkg.sv
package afp_pkg;
   typedef struct packed {
      logic over_temp;
      logic dc_detect;
      logic over_current;
      logic clock_bad;
      logic under_voltage;
      logic over_voltage;
   } afp_err_type;
   typedef enum logic [1:0] {
      AFP_RUN,
      AFP_LATCHED,
      AFP_WAIT_TIMEOUT
   } afp_state_type;
   typedef struct packed {
      logic pbtl;
      logic freq_low;
      logic [1:0] gain;
   } afp_strap_type;
endpackage

// ===== logic/afp_dc_detect.sv
`timescale 1ns/100ps
`include "afp_defines.svh"
module afp_dc_detect (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic duty_high,
   input wire logic duty_pos,
   output logic dc_err
);
   localparam int unsigned LIMIT = `AFP_DC_PERSIST_CYC;
   logic [31:0] cnt_q, cnt_d;
   logic pol_q, pol_d;
   logic err_q, err_d;
   assign dc_err = err_q;
   // Polarity change restarts the count, since the persistence must be
   // at one sign continuously.
   always_comb begin
      cnt_d = cnt_q;
      pol_d = duty_pos;
      err_d = 1'b0;
      if (!duty_high || duty_pos != pol_q) begin
         cnt_d = 32'h0000_0000;
      end else if (cnt_q <= LIMIT) begin
         cnt_d = cnt_q + 32'h0000_0001;
      end
      if (cnt_q > LIMIT) begin
         err_d = 1'b1; // [RULE11]
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= 32'h0000_0000;
         pol_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         pol_q <= pol_d;
         err_q <= err_d;
      end
   end
endmodule

// ===== logic/afp_fault_ctrl.sv
`timescale 1ns/100ps
`include "afp_defines.svh"
// Notes on behaviour
// [RULE1] Faults pull the open-drain fault line low; otherwise it is released.
// [RULE2] After a latched error the line stays low until shutdown toggle plus timeout.
// [RULE3] Self-clearing errors except clock never pull the fault line low.
// [RULE4] Clock error pulls the line low and clears at once when clocks recover.
// [RULE5] Overvoltage is self-clearing and ends when supply falls below threshold.
// [RULE6] Undervoltage is self-clearing and ends when supply rises above threshold.
// [RULE7] Clock error follows any bad ratio, bad rate or stopped clock.
// [RULE8] Overcurrent latches; clears after timeout and a shutdown toggle.
// [RULE9] DC error latches; clears after timeout and a shutdown toggle.
// [RULE10] Overtemperature latches; clearing also needs temperature below hysteresis.
// [RULE11] DC error when duty above 60 percent, same polarity, over 420 ms.
// [RULE12] The system may tie fault back to shutdown for auto-recovery; the line stays low in AFP_LATCHED, so a tied shutdown never rises.
// [RULE13] Hardware mode uses default configuration and only the control pins.
// [RULE14] All-low straps mean bridge-tied output and 768 kHz switching.
// [RULE15] The board fixes strap pins and never changes them in operation.
// [RULE16] Error still present at shutdown release sets status and faults again.
// [RULE17] Fault timeout counter starts when shutdown is released after a latch.
module afp_fault_ctrl #(
   parameter int unsigned TIMEOUT_CYC = `AFP_TIMEOUT_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic hw_mode,
   input wire logic amp_shutdown_n,
   input wire logic over_voltage_in,
   input wire logic under_voltage_in,
   input wire logic clk_ratio_bad,
   input wire logic clk_rate_bad,
   input wire logic clk_stopped,
   input wire logic over_current_in,
   input wire logic over_temp_in,
   input wire logic temp_below_hyst,
   input wire logic duty_high,
   input wire logic duty_pos,
   input wire afp_pkg::afp_strap_type strap_in,
   input wire logic amp_fault_n_in,
   output logic amp_fault_n_out,
   output logic amp_fault_n_oe,
   output logic amp_enable,
   output logic pbtl_mode,
   output logic freq_16x,
   output logic [1:0] gain_sel,
   output logic irq
);
   afp_pkg::afp_state_type st_q, st_d;
   afp_pkg::afp_err_type live, lat_q, lat_d;
   afp_pkg::afp_strap_type strap_q, strap_d;
   logic strap_done_q, strap_done_d;
   logic [31:0] tmo_q, tmo_d;
   logic sd_q, sd_d, fault_q, fault_d, en_q, en_d, irq_q, irq_d;
   logic [5:0] stat_q, stat_d, mask_q, mask_d;
   logic sd_bit_q, sd_bit_d;
   logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
   logic [11:0] awa_q, awa_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d;
   logic [1:0] br_q, br_d, rr_q, rr_d;
   logic dc_err, sd_eff, sd_rise, latch_evt, wr_go;
   afp_dc_detect u_dc (
      .aclk(aclk),
      .aresetn(aresetn),
      .duty_high(duty_high),
      .duty_pos(duty_pos),
      .dc_err(dc_err)
   );
   always_comb begin
      live.over_voltage = over_voltage_in; // [RULE5]
      live.under_voltage = under_voltage_in; // [RULE6]
      live.clock_bad = clk_ratio_bad | clk_rate_bad | clk_stopped; // [RULE7]
      live.over_current = over_current_in; // [RULE8]
      live.dc_detect = dc_err; // [RULE9]
      live.over_temp = over_temp_in; // [RULE10]
   end
   // In hardware mode the shutdown control bit is ignored.
   assign sd_eff = hw_mode ? amp_shutdown_n
                           : (amp_shutdown_n & sd_bit_q); // [RULE13]
   assign sd_rise = sd_eff & ~sd_q;
   assign latch_evt = live.over_current | live.dc_detect | live.over_temp;
   always_comb begin
      st_d = st_q;
      lat_d = lat_q;
      tmo_d = tmo_q;
      sd_d = sd_eff;
      case (st_q)
         afp_pkg::AFP_RUN: begin
            if (sd_eff && latch_evt) begin
               lat_d = live;
               st_d = afp_pkg::AFP_LATCHED; // [RULE8]
            end
         end
         afp_pkg::AFP_LATCHED: begin
            if (sd_rise) begin
               tmo_d = 32'h0000_0000; // [RULE17]
               st_d = afp_pkg::AFP_WAIT_TIMEOUT;
            end
         end
         afp_pkg::AFP_WAIT_TIMEOUT: begin
            if (!sd_eff) begin
               st_d = afp_pkg::AFP_LATCHED;
            end else if (tmo_q < TIMEOUT_CYC - 1) begin
               tmo_d = tmo_q + 32'h0000_0001; // [RULE17]
            end else if (latch_evt ||
                         (lat_q.over_temp && !temp_below_hyst)) begin
               lat_d = lat_q | live;
               st_d = afp_pkg::AFP_LATCHED; // [RULE16] [RULE10]
            end else begin
               lat_d = '0;
               st_d = afp_pkg::AFP_RUN; // [RULE2] [RULE9]
            end
         end
         default: st_d = afp_pkg::AFP_RUN;
      endcase
   end
   always_comb begin
      fault_d = (st_q != afp_pkg::AFP_RUN) || live.clock_bad; // [RULE2] [RULE4]
      // Supply errors only mute; they never reach the fault line.
      en_d = sd_eff && st_d == afp_pkg::AFP_RUN && !live.over_voltage &&
             !live.under_voltage && !live.clock_bad; // [RULE3]
      strap_d = strap_q;
      strap_done_d = 1'b1;
      // Straps are sampled once after reset, as the board holds them fixed.
      if (!strap_done_q) begin
         strap_d = strap_in; // [RULE15]
      end
   end
   assign wr_go = aw_q && w_q && !bv_q;
   always_comb begin
      aw_d = aw_q;
      w_d = w_q;
      awa_d = awa_q;
      wd_d = wd_q;
      bv_d = bv_q;
      br_d = br_q;
      rv_d = rv_q;
      rd_d = rd_q;
      rr_d = rr_q;
      mask_d = mask_q;
      sd_bit_d = sd_bit_q;
      stat_d = stat_q;
      if (s_axi_awvalid && !aw_q && !bv_q) begin
         aw_d = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q && !bv_q) begin
         w_d = 1'b1;
         wd_d = s_axi_wdata;
      end
      if (wr_go) begin
         aw_d = 1'b0;
         w_d = 1'b0;
         bv_d = 1'b1;
         br_d = `AFP_RESP_OKAY;
         case (awa_q)
            `AFP_ADDR_STATUS: stat_d = stat_q & ~wd_q[5:0];
            `AFP_ADDR_MASK: mask_d = wd_q[5:0];
            `AFP_ADDR_CTRL: sd_bit_d = wd_q[`AFP_CTRL_SD_BIT];
            `AFP_ADDR_LIVE, `AFP_ADDR_CONFIG: br_d = `AFP_RESP_OKAY;
            default: br_d = `AFP_RESP_SLVERR;
         endcase
      end else if (bv_q && s_axi_bready) begin
         bv_d = 1'b0;
      end
      // A new event wins over a clear in the same cycle.
      stat_d = stat_d | live | lat_d; // [RULE16]
      if (s_axi_arvalid && !rv_q) begin
         rv_d = 1'b1;
         rr_d = `AFP_RESP_OKAY;
         case (s_axi_araddr)
            `AFP_ADDR_STATUS: rd_d = {26'h0, stat_q};
            `AFP_ADDR_MASK: rd_d = {26'h0, mask_q};
            `AFP_ADDR_CTRL: rd_d = {31'h0, sd_bit_q};
            `AFP_ADDR_LIVE: rd_d = {24'h0, ~amp_fault_n_in, en_q, live};
            `AFP_ADDR_CONFIG: rd_d = {28'h0, strap_q};
            default: begin
               rd_d = 32'h0000_0000;
               rr_d = `AFP_RESP_SLVERR;
            end
         endcase
      end else if (rv_q && s_axi_rready) begin
         rv_d = 1'b0;
      end
      irq_d = |(stat_d & mask_d);
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= afp_pkg::AFP_RUN;
         lat_q <= '0;
         tmo_q <= 32'h0000_0000;
         sd_q <= 1'b0;
         fault_q <= 1'b0;
         en_q <= 1'b0;
         strap_q <= '0;
         strap_done_q <= 1'b0;
         stat_q <= 6'h00;
         mask_q <= 6'h00;
         sd_bit_q <= 1'b1;
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awa_q <= 12'h000;
         wd_q <= 32'h0000_0000;
         bv_q <= 1'b0;
         br_q <= 2'h0;
         rv_q <= 1'b0;
         rd_q <= 32'h0000_0000;
         rr_q <= 2'h0;
         irq_q <= 1'b0;
      end else begin
         st_q <= st_d;
         lat_q <= lat_d;
         tmo_q <= tmo_d;
         sd_q <= sd_d;
         fault_q <= fault_d;
         en_q <= en_d;
         strap_q <= strap_d;
         strap_done_q <= strap_done_d;
         stat_q <= stat_d;
         mask_q <= mask_d;
         sd_bit_q <= sd_bit_d;
         aw_q <= aw_d;
         w_q <= w_d;
         awa_q <= awa_d;
         wd_q <= wd_d;
         bv_q <= bv_d;
         br_q <= br_d;
         rv_q <= rv_d;
         rd_q <= rd_d;
         rr_q <= rr_d;
         irq_q <= irq_d;
      end
   end
   // Open drain: data is always low, only the enable moves.
   assign amp_fault_n_out = 1'b0; // [RULE1]
   assign amp_fault_n_oe = fault_q; // [RULE1]
   assign amp_enable = en_q;
   // Strap zero decodes to bridge-tied load and 16x switching.
   assign pbtl_mode = strap_q.pbtl; // [RULE14]
   assign freq_16x = ~strap_q.freq_low; // [RULE14]
   assign gain_sel = strap_q.gain;
   assign irq = irq_q;
   assign s_axi_awready = ~aw_q & ~bv_q;
   assign s_axi_wready = ~w_q & ~bv_q;
   assign s_axi_bvalid = bv_q;
   assign s_axi_bresp = br_q;
   assign s_axi_arready = ~rv_q;
   assign s_axi_rvalid = rv_q;
   assign s_axi_rdata = rd_q;
   assign s_axi_rresp = rr_q;

   property p_oe_follows_state;
      @(posedge aclk) disable iff (!aresetn)
      (st_q == afp_pkg::AFP_LATCHED) |=> amp_fault_n_oe;
   endproperty
   a_oe_follows_state: assert property (p_oe_follows_state) // [RULE2]
      else $error("fault line released while latched");
   property p_clock_fault;
      @(posedge aclk) disable iff (!aresetn)
      live.clock_bad |=> amp_fault_n_oe;
   endproperty
   a_clock_fault: assert property (p_clock_fault) // [RULE4]
      else $error("clock error did not pull fault low");
   property p_supply_no_fault;
      @(posedge aclk) disable iff (!aresetn)
      (st_q == afp_pkg::AFP_RUN && !live.clock_bad) |=> !amp_fault_n_oe;
   endproperty
   a_supply_no_fault: assert property (p_supply_no_fault) // [RULE3]
      else $error("fault line low without cause");
   property p_ov_mutes;
      @(posedge aclk) disable iff (!aresetn)
      over_voltage_in |=> !amp_enable;
   endproperty
   a_ov_mutes: assert property (p_ov_mutes) // [RULE5]
      else $error("amplifier enabled during overvoltage");
   property p_latch_oc;
      @(posedge aclk) disable iff (!aresetn)
      (st_q == afp_pkg::AFP_RUN && sd_eff && over_current_in)
         |=> st_q == afp_pkg::AFP_LATCHED;
   endproperty
   a_latch_oc: assert property (p_latch_oc) // [RULE8]
      else $error("overcurrent not latched");
   property p_start_timeout;
      @(posedge aclk) disable iff (!aresetn)
      (st_q == afp_pkg::AFP_LATCHED && sd_rise)
         |=> st_q == afp_pkg::AFP_WAIT_TIMEOUT && tmo_q == 0;
   endproperty
   a_start_timeout: assert property (p_start_timeout) // [RULE17]
      else $error("timeout did not start on release");
   property p_no_early_run;
      @(posedge aclk) disable iff (!aresetn)
      (st_q == afp_pkg::AFP_WAIT_TIMEOUT && tmo_q < TIMEOUT_CYC - 1)
         |=> st_q != afp_pkg::AFP_RUN;
   endproperty
   a_no_early_run: assert property (p_no_early_run) // [RULE2]
      else $error("resumed before timeout");
   property p_ot_hyst;
      @(posedge aclk) disable iff (!aresetn)
      (st_q == afp_pkg::AFP_WAIT_TIMEOUT && lat_q.over_temp &&
       !temp_below_hyst) |=> st_q != afp_pkg::AFP_RUN;
   endproperty
   a_ot_hyst: assert property (p_ot_hyst) // [RULE10]
      else $error("overtemp cleared above hysteresis");
endmodule

// ===== tb/afp_sys_ctrl.sv
`timescale 1ns/100ps
// System controller at the far end of the fault line.
module afp_sys_ctrl (
   input wire logic aclk,
   input wire logic fault_line,
   input wire logic auto_mode,
   input wire logic sd_req,
   output logic amp_shutdown_n
);
   logic sd_q = 1'h1;
   assign amp_shutdown_n = sd_q;
   // A register in the loop keeps the feedback from turning combinational.
   always @(posedge aclk) begin
      if (auto_mode) begin
         sd_q <= fault_line;
      end else begin
         sd_q <= sd_req;
      end
   end
endmodule

// ===== tb/amp_fault_protection_control_bench.sv
`timescale 1ns/100ps
`include "afp_defines.svh"
module amp_fault_protection_control_bench;
   localparam int TO = 8;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [11:0] awaddr = 12'h0;
   logic [11:0] araddr = 12'h0;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0;
   logic hw_mode = 1'h0, sd_req = 1'h1, auto_mode = 1'h0;
   logic ov = 1'h0, uv = 1'h0, c_ratio = 1'h0, c_rate = 1'h0;
   logic c_stop = 1'h0, oc = 1'h0, ot = 1'h0, hyst = 1'h1;
   logic duty_high = 1'h0, duty_pos = 1'h0;
   afp_pkg::afp_strap_type straps = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, sd_n;
   logic f_out, f_oe, amp_en, pbtl, f16, irq;
   logic [1:0] bresp, rresp, gain, resp;
   logic [31:0] rdata, rd;
   // Open-drain net with its pull-up.
   wire logic fault_line = f_oe ? f_out : 1'h1;
   int n_mismatch = 0, num_checks = 0, exp_st = 0, n, k;
   always #5 aclk = ~aclk;
   afp_fault_ctrl #(.TIMEOUT_CYC(TO)) u_afp_fault_ctrl (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .hw_mode(hw_mode), .amp_shutdown_n(sd_n),
      .over_voltage_in(ov), .under_voltage_in(uv),
      .clk_ratio_bad(c_ratio), .clk_rate_bad(c_rate),
      .clk_stopped(c_stop), .over_current_in(oc), .over_temp_in(ot),
      .temp_below_hyst(hyst), .duty_high(duty_high),
      .duty_pos(duty_pos), .strap_in(straps),
      .amp_fault_n_in(fault_line), .amp_fault_n_out(f_out),
      .amp_fault_n_oe(f_oe), .amp_enable(amp_en), .pbtl_mode(pbtl),
      .freq_16x(f16), .gain_sel(gain), .irq(irq));
   afp_sys_ctrl u_afp_sys_ctrl (.aclk(aclk), .fault_line(fault_line),
      .auto_mode(auto_mode), .sd_req(sd_req), .amp_shutdown_n(sd_n));
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk_reg(input string nm, input logic [31:0] e, g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_pin(input string nm, input logic e, g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic hang(input string nm);
      n_mismatch++;
      $display("mismatch %s expected answer seen timeout", nm);
      stop_test;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         if (bvalid) break;
      end
      if (i == 50) hang("write answer");
      resp = bresp;
      bready <= 1'h0;
   endtask
   task automatic rdr(input logic [11:0] a);
      int i;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'h0;
         if (rvalid) break;
      end
      if (i == 50) hang("read answer");
      rd = rdata;
      resp = rresp;
      rready <= 1'h0;
   endtask
   // Waits for the fault line to reach a level; n counts the edges taken.
   task automatic wfl(input logic e, input int mx);
      for (n = 0; n < mx; n++) begin
         if (fault_line === e) break;
         @(posedge aclk);
      end
      if (n == mx) hang("fault line");
   endtask
   task automatic toggle;
      sd_req <= 1'h0;
      repeat (3) @(posedge aclk);
      sd_req <= 1'h1;
   endtask
   task automatic trip(input logic is_ot);
      oc <= !is_ot;
      ot <= is_ot;
      wfl(1'h0, 6);
      chk_pin("fault line", 1'h0, fault_line);
      oc <= 1'h0;
      ot <= 1'h0;
      repeat (3 * TO) @(posedge aclk);
      chk_pin("held line", 1'h0, fault_line);
      chk_pin("latched mute", 1'h0, amp_en);
   endtask
   initial begin
      n = $urandom(32'h8a555c74);
      @(posedge aclk);
      // The board fixes the straps before reset ends.
      straps <= 4'($urandom);
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (3) @(posedge aclk);
      chk_pin("bridge mode", straps.pbtl, pbtl);
      chk_pin("freq 16x", !straps.freq_low, f16);
      chk_reg("gain", {30'h0, straps.gain}, {30'h0, gain});
      chk_pin("idle line", 1'h1, fault_line);
      rdr(`AFP_ADDR_CONFIG);
      chk_reg("config", {28'h0, straps}, rd);
      rdr(`AFP_ADDR_CTRL);
      chk_reg("ctrl", `AFP_CTRL_RESET, rd);
      rdr(12'h100);
      chk_reg("unmapped resp", {30'h0, `AFP_RESP_SLVERR}, {30'h0, resp});
      wr(12'h100, 32'h3f);
      chk_reg("unmapped wresp", {30'h0, `AFP_RESP_SLVERR}, {30'h0, resp});
      rdr(`AFP_ADDR_MASK);
      chk_reg("mask", `AFP_MASK_RESET, rd);
      // Supply errors recover alone and never touch the line.
      for (k = 0; k < 2; k++) begin
         ov <= (k == 0);
         uv <= (k == 1);
         repeat (3 + $urandom % 8) @(posedge aclk);
         chk_pin("supply line", 1'h1, fault_line);
         chk_pin("supply mute", 1'h0, amp_en);
         rdr(`AFP_ADDR_LIVE);
         chk_reg("live", 1 << k, rd);
         ov <= 1'h0;
         uv <= 1'h0;
         repeat (4) @(posedge aclk);
         chk_pin("supply resume", 1'h1, amp_en);
         exp_st |= 1 << k;
      end
      for (k = 0; k < 3; k++) begin
         c_ratio <= (k == 0);
         c_rate <= (k == 1);
         c_stop <= (k == 2);
         wfl(1'h0, 5);
         chk_pin("clock line", 1'h0, fault_line);
         c_ratio <= 1'h0;
         c_rate <= 1'h0;
         c_stop <= 1'h0;
         wfl(1'h1, 4);
         chk_pin("clock recover", 1'h1, fault_line);
      end
      exp_st |= 1 << `AFP_ST_CLK;
      rdr(`AFP_ADDR_STATUS);
      chk_reg("status", exp_st, rd);
      chk_pin("masked irq", 1'h0, irq);
      wr(`AFP_ADDR_MASK, 32'h3f);
      chk_reg("mask wresp", {30'h0, `AFP_RESP_OKAY}, {30'h0, resp});
      repeat (2) @(posedge aclk);
      chk_pin("irq", 1'h1, irq);
      wr(`AFP_ADDR_STATUS, exp_st);
      exp_st = 0;
      rdr(`AFP_ADDR_STATUS);
      chk_reg("cleared", exp_st, rd);
      repeat (2) @(posedge aclk);
      chk_pin("irq off", 1'h0, irq);
      // Random duty bursts far shorter than the persistence time.
      for (k = 0; k < 300; k++) begin
         duty_high <= 1'($urandom);
         duty_pos <= 1'($urandom);
         @(posedge aclk);
      end
      duty_high <= 1'h0;
      chk_pin("short duty", 1'h1, fault_line);
      trip(1'h0);
      toggle;
      wfl(1'h1, 4 * TO);
      chk_pin("release time", 1'h1, n >= TO && n <= TO + 6);
      hyst <= 1'h0;
      trip(1'h1);
      toggle;
      repeat (4 * TO) @(posedge aclk);
      chk_pin("hot line", 1'h0, fault_line);
      hyst <= 1'h1;
      toggle;
      wfl(1'h1, 4 * TO);
      chk_pin("cool release", 1'h1, fault_line);
      exp_st = (1 << `AFP_ST_OC) | (1 << `AFP_ST_OT);
      oc <= 1'h1;
      wfl(1'h0, 6);
      toggle;
      repeat (4 * TO) @(posedge aclk);
      chk_pin("persist line", 1'h0, fault_line);
      wr(`AFP_ADDR_STATUS, exp_st);
      rdr(`AFP_ADDR_STATUS);
      chk_reg("persist status", 1 << `AFP_ST_OC, rd);
      oc <= 1'h0;
      toggle;
      wfl(1'h1, 4 * TO);
      chk_pin("persist release", 1'h1, fault_line);
      wr(`AFP_ADDR_CTRL, 32'h0);
      repeat (3) @(posedge aclk);
      chk_pin("bit shutdown", 1'h0, amp_en);
      wr(`AFP_ADDR_CTRL, 32'h1);
      hw_mode <= 1'h1;
      wr(`AFP_ADDR_CTRL, 32'h0);
      repeat (3) @(posedge aclk);
      chk_pin("pins only", 1'h1, amp_en);
      // A second reset must resample the straps, now all low.
      straps <= 4'h0;
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      chk_pin("reset mute", 1'h0, amp_en);
      aresetn <= 1'h1;
      repeat (3) @(posedge aclk);
      chk_pin("bridge mode", 1'h0, pbtl);
      chk_pin("freq 16x", 1'h1, f16);
      chk_pin("reset irq", 1'h0, irq);
      chk_pin("reset line", 1'h1, fault_line);
      stop_test;
   end
endmodule
